// ### include/host_regs_params.svh
// Constants for the host control and status register bank
// How it works
// - TX self-test done bit12, fail bit11, read-only
// - RX self-test done bit4, fail bit3, read-only
// - Soft reset bit0 set holds, clear releases
// - Soft reset hits core, bus unit kept
// - Bus width bit loaded from EEPROM word
// - One means 16-bit bus, zero 8-bit
// - Pause generation bit3 needs switch-level enable
// - Pad bit2 pads frames under 64 bytes
// - CRC bit1 appends checksum to each frame
// - Run bit0 clear stops after current frame
// - Status holds last frame identifier bits 5:0
// - Banks 4-15 empty except bank select 0xE
`ifndef HOST_REGS_PARAMS_SVH
`define HOST_REGS_PARAMS_SVH
`define OFS_SELFTEST      4'h4
`define OFS_SOFT_RESET    4'h6
`define OFS_BUS_WIDTH     4'h8
`define OFS_TX_CONTROL    4'h0
`define OFS_TX_STATUS     4'h2
`define OFS_BANK_SELECT   4'hE
`define BANK_SELFTEST     5'h03
`define BANK_TX           5'h10
`define BIT_TX_ST_DONE    12
`define BIT_TX_ST_FAIL    11
`define BIT_RX_ST_DONE    4
`define BIT_RX_ST_FAIL    3
`define BIT_SOFT_RESET    0
`define BIT_BUS_WIDTH     0
`define BIT_PAUSE_EN      3
`define BIT_PAD_EN        2
`define BIT_CRC_EN        1
`define BIT_RUN_EN        0
`define TX_CTRL_MASK      16'h000F
`define TX_ID_MASK        16'h003F
`define MIN_FRAME_BYTES   11'h040
`endif

// ### include/host_regs_pkg.sv
// Types shared by the register bank
package host_regs_pkg;
    typedef logic [15:0] word_t;    // Host bus data word
    typedef logic [5:0]  frame_id_t; // Transmit frame identifier
    typedef enum logic [1:0] {
        TX_STOPPED = 2'b01,
        TX_RUNNING = 2'b10
    } tx_state_e;
endpackage : host_regs_pkg

// ### rtl/tx_run_ctrl.sv
// Transmit run/stop sequencer and pad/status path
`timescale 1ns/100ps
`include "host_regs_params.svh"
module tx_run_ctrl
    import host_regs_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,        // Combined hard/soft reset
    input  wire logic      run_en_i,
    input  wire logic      frame_start_i,  // Start request from queue
    input  wire logic      frame_done_i,   // Current frame finished
    input  wire frame_id_t frame_id_i,     // ID of frame finishing
    input  wire logic [10:0] frame_len_i,  // Length of frame starting
    output logic           running_o,
    output logic           busy_o,
    output logic           pad_needed_o,
    output frame_id_t      last_id_o
);
    tx_state_e   state_r, state_nxt;   // Run state
    logic        busy_r, busy_nxt;     // Frame in flight
    logic        pad_r, pad_nxt;       // Short-frame marker
    frame_id_t   id_r, id_nxt;         // Last sent frame ID

    // Next-state logic
    always_comb begin
        state_nxt = state_r;
        busy_nxt  = busy_r;
        pad_nxt   = pad_r;
        id_nxt    = id_r;
        case (state_r)
            TX_STOPPED: begin
                if (run_en_i && !busy_r) begin
                    state_nxt = TX_RUNNING;
                end
            end
            TX_RUNNING: begin
                // Stop waits for the frame in flight to end
                if (!run_en_i && (!busy_r || frame_done_i)) begin
                    state_nxt = TX_STOPPED;
                end
            end
            default: state_nxt = TX_STOPPED;
        endcase
        if (busy_r && frame_done_i) begin
            busy_nxt = 1'b0;
            id_nxt   = frame_id_i;
        end else if (!busy_r && frame_start_i && state_r == TX_RUNNING && run_en_i) begin
            busy_nxt = 1'b1;
            pad_nxt  = (frame_len_i < `MIN_FRAME_BYTES);
        end
    end

    // State registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= TX_STOPPED;
            busy_r  <= 1'b0;
            pad_r   <= 1'b0;
            id_r    <= 6'h00;
        end else begin
            state_r <= state_nxt;
            busy_r  <= busy_nxt;
            pad_r   <= pad_nxt;
            id_r    <= id_nxt;
        end
    end

    assign running_o    = (state_r == TX_RUNNING);
    assign busy_o       = busy_r;
    assign pad_needed_o = pad_r;
    assign last_id_o    = id_r;
endmodule : tx_run_ctrl

// ### rtl/host_ctrl_status_regs.sv
// Host-visible control/status registers for self-test, reset, bus width and transmit
`timescale 1ns/100ps
`include "host_regs_params.svh"
module host_ctrl_status_regs
    import host_regs_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    // Banked host register port
    input  wire logic        reg_wr_i,          // Write strobe, one cycle
    input  wire logic        reg_rd_i,          // Read strobe, one cycle
    input  wire logic [3:0]  reg_addr_i,        // Byte offset within bank
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic [1:0]  reg_be_i,          // Byte enables
    output logic [15:0]      reg_rdata_o,       // Registered read data
    output logic [4:0]       bank_o,            // Current bank
    // Self-test results from buffer memories
    input  wire logic        tx_selftest_done_i,
    input  wire logic        tx_selftest_failed_i,
    input  wire logic        rx_selftest_done_i,
    input  wire logic        rx_selftest_failed_i,
    // EEPROM load
    input  wire logic        eeprom_enable_input_i,  // Strap pin
    input  wire logic        cfg_word_valid_i,       // Config word loaded, pulse
    input  wire logic [15:0] cfg_word_i,
    // Switch-level controls
    input  wire logic        switch_global_control_three_pause_i,
    input  wire logic        rx_fifo_threshold_i,
    // Transmit frame path
    input  wire logic        frame_start_i,
    input  wire logic        frame_done_i,
    input  wire frame_id_t   frame_id_i,
    input  wire logic [10:0] frame_len_i,
    // Outputs, all flopped
    output logic             core_reset_n_o,    // Soft reset to core, low active
    output logic             tx_running_o,
    output logic             tx_busy_o,
    output logic             tx_pad_o,
    output logic             tx_crc_append_o,
    output logic             tx_pause_req_o
);
    logic        rst_s1_r, rst_n_r;      // Reset release synchroniser
    logic [1:0]  een_sync_r;             // Strap synchroniser
    logic [1:0]  st_sync0_r, st_sync1_r; // Self-test synchronisers, two stages
    logic [3:0]  st_flags;               // Synchronised self-test inputs
    logic [4:0]  bank_r, bank_nxt;       // Bank select
    logic        soft_rst_r, soft_rst_nxt;
    logic        bus_w_r, bus_w_nxt;
    logic [3:0]  txc_r, txc_nxt;         // Transmit control bits
    logic [15:0] rdata_r, rdata_nxt;
    logic        core_rn_r, pause_r, pad_r, crc_r, run_r, busy_r;
    logic        run_w, busy_w, pad_w;
    frame_id_t   last_id_w;
    logic        core_rst_n;

    // Reset release through two flops
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // Pin synchronisers; first stage read only by second
    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            een_sync_r <= 2'h0;
            st_sync0_r <= 2'h0;
            st_sync1_r <= 2'h0;
        end else begin
            een_sync_r <= {een_sync_r[0], eeprom_enable_input_i};
            st_sync0_r <= {st_sync0_r[0], tx_selftest_done_i};
            st_sync1_r <= {st_sync1_r[0], rx_selftest_done_i};
        end
    end

    // Failure flags are only meaningful once done is seen; sampled with done
    logic [1:0] fail_tx_r, fail_rx_r;
    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            fail_tx_r <= 2'h0;
            fail_rx_r <= 2'h0;
        end else begin
            fail_tx_r <= {fail_tx_r[0], tx_selftest_failed_i};
            fail_rx_r <= {fail_rx_r[0], rx_selftest_failed_i};
        end
    end
    assign st_flags = {st_sync0_r[1], fail_tx_r[1], st_sync1_r[1], fail_rx_r[1]};

    // Core reset: hard reset or soft reset bit
    assign core_rst_n = rst_n_r & ~soft_rst_r;

    // Register next values
    always_comb begin
        bank_nxt     = bank_r;
        soft_rst_nxt = soft_rst_r;
        bus_w_nxt    = bus_w_r;
        txc_nxt      = txc_r;
        rdata_nxt    = rdata_r;
        // Config bit loads only with EEPROM present
        if (een_sync_r[1] && cfg_word_valid_i) begin
            bus_w_nxt = cfg_word_i[`BIT_BUS_WIDTH];
        end
        if (reg_wr_i && reg_be_i[0]) begin
            if (reg_addr_i == `OFS_BANK_SELECT) begin
                bank_nxt = reg_wdata_i[4:0];
            end else if (bank_r == `BANK_SELFTEST && reg_addr_i == `OFS_SOFT_RESET) begin
                soft_rst_nxt = reg_wdata_i[`BIT_SOFT_RESET];
            end else if (bank_r == `BANK_TX && reg_addr_i == `OFS_TX_CONTROL) begin
                txc_nxt = reg_wdata_i[3:0];
            end
            // Other writes, incl. read-only registers, dropped
        end
        if (reg_rd_i) begin
            rdata_nxt = 16'h0000;
            if (reg_addr_i == `OFS_BANK_SELECT) begin
                rdata_nxt[4:0] = bank_r;
            end else if (bank_r == `BANK_SELFTEST) begin
                case (reg_addr_i)
                    `OFS_SELFTEST: begin
                        rdata_nxt[`BIT_TX_ST_DONE] = st_flags[3];
                        rdata_nxt[`BIT_TX_ST_FAIL] = st_flags[3] & st_flags[2];
                        rdata_nxt[`BIT_RX_ST_DONE] = st_flags[1];
                        rdata_nxt[`BIT_RX_ST_FAIL] = st_flags[1] & st_flags[0];
                    end
                    `OFS_SOFT_RESET: rdata_nxt[`BIT_SOFT_RESET] = soft_rst_r;
                    `OFS_BUS_WIDTH:  rdata_nxt[`BIT_BUS_WIDTH] = bus_w_r & een_sync_r[1];
                    default: rdata_nxt = 16'h0000;
                endcase
            end else if (bank_r == `BANK_TX) begin
                case (reg_addr_i)
                    `OFS_TX_CONTROL: rdata_nxt[3:0] = txc_r;
                    `OFS_TX_STATUS:  rdata_nxt[5:0] = last_id_w;
                    default:         rdata_nxt = 16'h0000;
                endcase
            end
        end
    end

    // Bus-unit registers survive soft reset
    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            bank_r     <= 5'h00;
            soft_rst_r <= 1'b0;
            bus_w_r    <= 1'b0;
            rdata_r    <= 16'h0000;
        end else begin
            bank_r     <= bank_nxt;
            soft_rst_r <= soft_rst_nxt;
            bus_w_r    <= bus_w_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    // Transmit control belongs to the queue side, cleared by soft reset
    always_ff @(posedge ref_clk_i or negedge core_rst_n) begin
        if (!core_rst_n) begin
            txc_r <= 4'h0;
        end else begin
            txc_r <= txc_nxt;
        end
    end

    // Run/stop and frame status sequencer
    tx_run_ctrl u_tx_run (
        .clk_i        (ref_clk_i),
        .rst_n_i      (core_rst_n),
        .run_en_i     (txc_r[`BIT_RUN_EN]),
        .frame_start_i(frame_start_i),
        .frame_done_i (frame_done_i),
        .frame_id_i   (frame_id_i),
        .frame_len_i  (frame_len_i),
        .running_o    (run_w),
        .busy_o       (busy_w),
        .pad_needed_o (pad_w),
        .last_id_o    (last_id_w)
    );

    // Output flops
    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            core_rn_r <= 1'b0;
            pause_r   <= 1'b0;
            pad_r     <= 1'b0;
            crc_r     <= 1'b0;
            run_r     <= 1'b0;
            busy_r    <= 1'b0;
        end else begin
            core_rn_r <= ~soft_rst_r;
            pause_r   <= txc_r[`BIT_PAUSE_EN] & switch_global_control_three_pause_i
                         & rx_fifo_threshold_i;
            pad_r     <= txc_r[`BIT_PAD_EN] & pad_w;
            crc_r     <= txc_r[`BIT_CRC_EN];
            run_r     <= run_w;
            busy_r    <= busy_w;
        end
    end

    assign reg_rdata_o     = rdata_r;
    assign bank_o          = bank_r;
    assign core_reset_n_o  = core_rn_r;
    assign tx_pause_req_o  = pause_r;
    assign tx_pad_o        = pad_r;
    assign tx_crc_append_o = crc_r;
    assign tx_running_o    = run_r;
    assign tx_busy_o       = busy_r;
endmodule : host_ctrl_status_regs

// ### tb/host_regs_checker_assertions.sv
// Port-level checker for the host control and status register bank
`timescale 1ns/100ps
module host_regs_checker
    import host_regs_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic [1:0]  reg_be_i,
    input  wire logic [15:0] reg_rdata_o,
    input  wire logic [4:0]  bank_o,
    input  wire logic        switch_global_control_three_pause_i,
    input  wire logic        frame_start_i,
    input  wire logic        core_reset_n_o,
    input  wire logic        tx_running_o,
    input  wire logic        tx_busy_o,
    input  wire logic        tx_pause_req_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // Read strobes decoded per bank and offset
    logic rd_st;
    logic rd_bc;
    logic rd_ts;
    logic rd_empty;
    logic wr_ok;  // Write with low byte lane enabled
    assign rd_st    = reg_rd_i && bank_o == 5'h03 && reg_addr_i == 4'h4;
    assign rd_bc    = reg_rd_i && bank_o == 5'h03 && reg_addr_i == 4'h8;
    assign rd_ts    = reg_rd_i && bank_o == 5'h10 && reg_addr_i == 4'h2;
    assign rd_empty = reg_rd_i && bank_o inside {[5'h04:5'h0F]} && reg_addr_i != 4'hE;
    assign wr_ok    = reg_wr_i && reg_be_i[0];
    property p_bank_sel;
        wr_ok && reg_addr_i == 4'hE |=> bank_o == $past(reg_wdata_i[4:0]);
    endproperty
    a_bank_sel: assert property (p_bank_sel) else $error("bank select not loaded");
    property p_soft_rst;
        wr_ok && bank_o == 5'h03 && reg_addr_i == 4'h6 && reg_wdata_i[0] |-> ##[1:3] !core_reset_n_o;
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("core not held in reset");
    property p_empty;
        rd_empty |=> reg_rdata_o == 16'h0000;
    endproperty
    a_empty: assert property (p_empty) else $error("empty bank read nonzero");
    property p_st_rsvd;
        rd_st |=> (reg_rdata_o & 16'hE7E7) == 16'h0000;
    endproperty
    a_st_rsvd: assert property (p_st_rsvd) else $error("self-test reserved bits set");
    property p_fail_done;
        rd_st |=> (!reg_rdata_o[11] || reg_rdata_o[12]) && (!reg_rdata_o[3] || reg_rdata_o[4]);
    endproperty
    a_fail_done: assert property (p_fail_done) else $error("fail flag without done");
    property p_bus_cfg;
        rd_bc |=> reg_rdata_o[15:1] == 15'h0000;
    endproperty
    a_bus_cfg: assert property (p_bus_cfg) else $error("bus width upper bits set");
    property p_transmit_frame_status;
        rd_ts |=> reg_rdata_o[15:6] == 10'h000;
    endproperty
    a_transmit_frame_status: assert property (p_transmit_frame_status) else $error("frame status upper bits set");
    property p_pause;
        (!switch_global_control_three_pause_i)[*4] |-> !tx_pause_req_o;
    endproperty
    a_pause: assert property (p_pause) else $error("pause without switch enable");
    property p_busy_start;
        $rose(tx_busy_o) |-> $past(frame_start_i, 2);
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy without start");
    property p_stop;
        $fell(tx_running_o) |-> !tx_busy_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stopped mid frame");
    // Main scenarios reached
    c_soft_rst: cover property (!core_reset_n_o);
    c_frame: cover property ($rose(tx_busy_o));
    c_pause: cover property (tx_pause_req_o);
endmodule : host_regs_checker
bind host_ctrl_status_regs host_regs_checker u_chk (.ref_clk_i, .rstn_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_be_i, .reg_rdata_o, .bank_o,
    .switch_global_control_three_pause_i, .frame_start_i, .core_reset_n_o, .tx_running_o,
    .tx_busy_o, .tx_pause_req_o);

// ### tb/host_bus_model.sv
// Host processor model driving the banked register port
`timescale 1ns/100ps
module host_bus_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] rdata_i,
    output logic             wr_o,
    output logic             rd_o,
    output logic [3:0]       addr_o,
    output logic [15:0]      wdata_o,
    output logic [1:0]       be_o
);
    // Idle bus at time zero
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 4'h0;
        wdata_o = 16'h0000;
        be_o = 2'b00;
    end
    // One-cycle write strobe; released data shows its inverse, never a stale copy
    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        be_o <= be;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask : wr
    // One-cycle read strobe; data sampled once it has settled
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
        d = rdata_i;
    endtask : rd
endmodule : host_bus_model

// ### tb/tb.sv
// Self-checking bench for the host control and status register bank
`timescale 1ns/100ps
module tb
    import host_regs_pkg::*;
;
    logic clk, rstn, st_txd, st_txf, st_rxd, st_rxf, ee_en, cfg_v, sw_pause, thr, f_start, f_done;
    logic [15:0] cfg_w;
    frame_id_t   f_id;   // Identifier of finishing frame
    logic [10:0] f_len;  // Length of starting frame
    logic h_wr, h_rd, core_n, run, busy, pad, crc, pause;
    logic [3:0]  h_addr;
    logic [15:0] h_wdata, rdata;
    logic [1:0]  h_be;
    logic [4:0]  bank;
    int n_errors = 0;
    int n_checks = 0;
    host_bus_model u_host (.clk_i(clk), .rdata_i(rdata), .wr_o(h_wr), .rd_o(h_rd),
        .addr_o(h_addr), .wdata_o(h_wdata), .be_o(h_be));
    host_ctrl_status_regs u_dut (.ref_clk_i(clk), .rstn_i(rstn), .reg_wr_i(h_wr),
        .reg_rd_i(h_rd), .reg_addr_i(h_addr), .reg_wdata_i(h_wdata), .reg_be_i(h_be),
        .reg_rdata_o(rdata), .bank_o(bank), .tx_selftest_done_i(st_txd),
        .tx_selftest_failed_i(st_txf), .rx_selftest_done_i(st_rxd),
        .rx_selftest_failed_i(st_rxf), .eeprom_enable_input_i(ee_en), .cfg_word_valid_i(cfg_v),
        .cfg_word_i(cfg_w), .switch_global_control_three_pause_i(sw_pause),
        .rx_fifo_threshold_i(thr), .frame_start_i(f_start), .frame_done_i(f_done),
        .frame_id_i(f_id), .frame_len_i(f_len), .core_reset_n_o(core_n),
        .tx_running_o(run), .tx_busy_o(busy), .tx_pad_o(pad), .tx_crc_append_o(crc),
        .tx_pause_req_o(pause));
    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk_w(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_w
    task automatic chk_f(input string nm, input logic e, input logic g);
        chk_w(nm, {15'h0000, e}, {15'h0000, g});
    endtask : chk_f
    task automatic rchk(input logic [3:0] a, input logic [15:0] e, input string nm);
        logic [15:0] d;
        u_host.rd(a, d);
        chk_w(nm, e, d);
    endtask : rchk
    // Register write plus output pipeline, with margin
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic frame_go(input logic [10:0] len);
        @(posedge clk);
        f_start <= 1'b1;
        f_len <= len;
        @(posedge clk);
        f_start <= 1'b0;
        settle();
    endtask : frame_go
    task automatic frame_end(input frame_id_t id);
        @(posedge clk);
        f_done <= 1'b1;
        f_id <= id;
        @(posedge clk);
        f_done <= 1'b0;
        settle();
    endtask : frame_end
    task automatic final_report();
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    // Watchdog far beyond the expected few hundred cycles
    initial begin
        #40000;
        n_errors++;
        final_report();
    end
    initial begin
        {rstn, st_txd, st_txf, st_rxd, st_rxf, ee_en, cfg_v, sw_pause, thr, f_start, f_done} = '0;
        cfg_w = 16'h0000;
        f_id = 6'h00;
        f_len = 11'h000;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        // Self-test flags, bank 3
        {st_txd, st_txf, st_rxd, st_rxf} <= 4'b1110;
        u_host.wr(4'hE, 16'h0003, 2'b11);
        settle();
        chk_w("bank", 16'h0003, {11'h000, bank});
        rchk(4'h4, 16'h1810, "selftest");
        u_host.wr(4'h4, 16'hFFFF, 2'b11);
        rchk(4'h4, 16'h1810, "selftest_ro");
        // RX failure shows; TX failure masked while TX not done
        @(posedge clk);
        {st_txd, st_rxf} <= 2'b01;
        settle();
        rchk(4'h4, 16'h0018, "selftest_rx_fail");
        rchk(4'h6, 16'h0000, "soft_rst_init");
        u_host.wr(4'h6, 16'hFFFF, 2'b11);
        rchk(4'h6, 16'h0001, "soft_rst_set");
        settle();
        chk_f("core_held", 1'b0, core_n);
        chk_w("bank_kept", 16'h0003, {11'h000, bank});
        u_host.wr(4'h6, 16'h0000, 2'b11);
        settle();
        chk_f("core_free", 1'b1, core_n);
        // Bus width loaded from the config word, both widths
        // Strap needs two edges through its synchroniser before a load
        @(posedge clk);
        ee_en <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            cfg_v <= 1'b1;
            cfg_w <= {15'h7FFF, ~i[0]};
            @(posedge clk);
            cfg_v <= 1'b0;
            settle();
            rchk(4'h8, {15'h0000, ~i[0]}, "bus_width");
        end
        // Without the strap the loaded one must read as zero
        @(posedge clk);
        ee_en <= 1'b0;
        settle();
        rchk(4'h8, 16'h0000, "bus_width_off");
        // Empty bank keeps only bank select
        u_host.wr(4'hE, 16'h0005, 2'b11);
        u_host.wr(4'h0, 16'hFFFF, 2'b11);
        rchk(4'h0, 16'h0000, "empty_bank");
        rchk(4'hE, 16'h0005, "bank_read");
        // Transmit bank: control bits, low byte lane, run, CRC and pause outputs
        u_host.wr(4'hE, 16'h0010, 2'b11);
        u_host.wr(4'h0, 16'hFFFF, 2'b11);
        rchk(4'h0, 16'h000F, "tx_ctl");
        u_host.wr(4'h0, 16'h0000, 2'b10);
        rchk(4'h0, 16'h000F, "tx_ctl_be");
        chk_f("running", 1'b1, run);
        chk_f("crc", 1'b1, crc);
        @(posedge clk);
        {sw_pause, thr} <= 2'b11;
        settle();
        chk_f("pause_on", 1'b1, pause);
        @(posedge clk);
        sw_pause <= 1'b0;
        settle();
        chk_f("pause_off", 1'b0, pause);
        // Pad boundary around the minimum frame length
        for (int i = 63; i < 65; i++) begin
            frame_go(11'(i));
            chk_f("busy", 1'b1, busy);
            chk_f("pad", i < 64, pad);
            frame_end(6'(i));
        end
        // Stop request mid frame waits for completion
        frame_go(11'h028);
        u_host.wr(4'h0, 16'h0006, 2'b11);
        settle();
        chk_f("run_held", 1'b1, run);
        frame_end(6'h2A);
        chk_f("run_stop", 1'b0, run);
        chk_f("busy_end", 1'b0, busy);
        rchk(4'h2, 16'h002A, "frame_id");
        u_host.wr(4'h0, 16'h0008, 2'b11);
        settle();
        chk_f("crc_off", 1'b0, crc);
        // Soft reset clears transmit control; bank select rewritten to the transmit bank before the read
        u_host.wr(4'hE, 16'h0003, 2'b11);
        u_host.wr(4'h6, 16'h0001, 2'b11);
        u_host.wr(4'h6, 16'h0000, 2'b11);
        u_host.wr(4'hE, 16'h0010, 2'b11);
        rchk(4'h0, 16'h0000, "tx_ctl_soft");
        final_report();
    end
endmodule : tb
